// file: design/bpp_pkg.sv
// bpp_pkg: constants, modes and state record of the button/pin/pwm block
// assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data
package bpp_pkg;
    localparam int          NPIN      = 21;
    localparam int          NANA      = 6;
    localparam int          CLK_NS    = 10;
    localparam int          US_NS     = 1000;
    localparam int          CYC_US    = US_NS / CLK_NS;
    localparam int          DEB_MS    = 10;
    localparam int          DEB_CYC   = DEB_MS * 1000 * CYC_US;
    localparam logic [31:0] MIN_MS    = 32'h00000001;
    localparam logic [31:0] MAX_MS    = 32'h00004189;
    localparam logic [31:0] US_PER_MS = 32'h000003e8;
    localparam logic [31:0] MIN_US    = 32'h00000100;
    localparam logic [31:0] MAX_US    = 32'h00ffffff;
    localparam logic [31:0] DUTY_MAX  = 32'h000003ff;
    localparam logic [23:0] PER_RST   = 24'h004e20;
    // pin capability masks, bit n is pin n
    localparam logic [20:0] ANA_MASK  = 21'h00041f;
    localparam logic [20:0] TCH_MASK  = 21'h000007;
    localparam logic [20:0] GAP_MASK  = 21'h060000;
    localparam logic [1:0]  PULL_NONE = 2'h0;
    localparam logic [1:0]  PULL_DOWN = 2'h1;
    localparam logic [1:0]  PULL_UP   = 2'h2;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;
    localparam logic [7:0]  A_HELD    = 8'h00;
    localparam logic [7:0]  A_LATCH   = 8'h04;
    localparam logic [7:0]  A_CNTA    = 8'h08;
    localparam logic [7:0]  A_CNTB    = 8'h0c;
    localparam logic [7:0]  A_SEL     = 8'h10;
    localparam logic [7:0]  A_DIG     = 8'h14;
    localparam logic [7:0]  A_PULL    = 8'h18;
    localparam logic [7:0]  A_MODE    = 8'h1c;
    localparam logic [7:0]  A_PWM     = 8'h20;
    localparam logic [7:0]  A_PER_MS  = 8'h24;
    localparam logic [7:0]  A_PER_US  = 8'h28;
    localparam logic [7:0]  A_ANALOG  = 8'h2c;
    localparam logic [7:0]  A_TOUCH   = 8'h30;
    localparam logic [7:0]  A_LEVELS  = 8'h34;

    typedef enum logic [3:0] {
        M_UNUSED, M_ANALOG, M_RDIG, M_WDIG, M_DISPLAY, M_BUTTON,
        M_MUSIC, M_AUDIO, M_TOUCH, M_I2C, M_SPI
    } bpp_mode_e;

    typedef struct packed {
        logic [1:0]             bs1, bs2, stab, latch;
        logic [1:0][23:0]       deb;
        logic [1:0][15:0]       cnt;
        logic [20:0]            ps1, ps2, dout, pwm_on;
        logic [20:0]            pin_o, pin_oe_n, pu_en, pd_en;
        logic [2:0]             ts1, ts2;
        logic [4:0]             sel;
        bpp_mode_e [20:0]       mode;
        logic [20:0][1:0]       pull;
        logic [20:0][9:0]       duty;
        logic [23:0]            per_us, phase;
        logic [6:0]             tick;
        logic                   aw_have, w_have;
        logic [7:0]             awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   awready, wready, bvalid, arready, rvalid;
        logic [1:0]             bresp, rresp;
        logic [31:0]            rdata;
    } bpp_state_s;
endpackage

// file: design/bpp_top.sv
// bpp_top: two buttons, 21-position pin bank with pulls, modes and pwm
// assumes buttons pulled up externally, touch comparator outputs on
// touch_low, and a same-clock adc presenting one code per analog pin
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

module bpp_top
    import bpp_pkg::*;
#(
    parameter logic [23:0] DEB_CYCLES = 24'(DEB_CYC)
)(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic [1:0]         btn_n,
    input  wire logic [20:0]        pin_i,
    output logic [20:0]             pin_o,
    output logic [20:0]             pin_oe_n,
    output logic [20:0]             pull_up_en,
    output logic [20:0]             pull_dn_en,
    input  wire logic [2:0]         touch_low,
    input  wire logic [5:0][9:0]    adc_code
);
    bpp_state_s r;
    bpp_state_s n;

    // adc channel of an analog pin; pin 10 rides the last channel
    function automatic logic [2:0] ana_ch(input logic [4:0] p);
        if (p == 5'h0a)
        begin
            return 3'h5;
        end
        return p[2:0];
    endfunction

    function automatic logic pin_ok(input logic [4:0] p);
        return (p < 5'(NPIN)) && !GAP_MASK[p];
    endfunction

    // high while phase*1023 < duty*period, exact at both ends
    function automatic logic pwm_lvl(
        input logic [9:0]  d,
        input logic [23:0] ph,
        input logic [23:0] pr
    );
        logic [33:0] a;
        logic [33:0] b;
        a = 34'(ph) * 34'h3ff;
        b = 34'(d) * 34'(pr);
        return a < b;
    endfunction

    logic [1:0]  press;
    logic [1:0]  clr_l;
    logic [1:0]  clr_c;
    logic [4:0]  s;
    logic        ok;
    logic        drv;
    logic [31:0] wd;
    logic [31:0] ms_us;

    always_comb
    begin
        n = r;
        press = '0;
        clr_l = '0;
        clr_c = '0;
        s = r.sel;
        ok = pin_ok(r.sel);
        drv = 1'b0;
        wd = r.wdata;
        ms_us = r.wdata * US_PER_MS;

        n.bs1 = ~btn_n;
        n.bs2 = r.bs1;
        n.ps1 = pin_i;
        n.ps2 = r.ps1;
        n.ts1 = touch_low;
        n.ts2 = r.ts1;

        // a level must stay put for the whole window before it counts
        for (int b = 0; b < 2; b++)
        begin
            if (r.bs2[b] == r.stab[b])
            begin
                n.deb[b] = '0;
            end
            else if (r.deb[b] >= DEB_CYCLES - 24'h000001)
            begin
                n.stab[b] = r.bs2[b];
                n.deb[b] = '0;
            end
            else
            begin
                n.deb[b] = r.deb[b] + 24'h000001;
            end
        end
        press = n.stab & ~r.stab;

        // microsecond tick and pwm phase
        if (r.tick == 7'(CYC_US - 1))
        begin
            n.tick = '0;
            if (r.phase + 24'h000001 >= r.per_us)
            begin
                n.phase = '0;
            end
            else
            begin
                n.phase = r.phase + 24'h000001;
            end
        end
        else
        begin
            n.tick = r.tick + 7'h01;
        end

        // read channel: side effects land with the address handshake
        if (r.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (r.arready && s_axi_arvalid)
        begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OK;
            n.rdata = '0;
            if (s_axi_araddr == A_HELD)
            begin
                n.rdata = 32'(r.stab);
            end
            else if (s_axi_araddr == A_LATCH)
            begin
                n.rdata = 32'(r.latch);
                clr_l = 2'b11;
            end
            else if (s_axi_araddr == A_CNTA)
            begin
                n.rdata = 32'(r.cnt[0]);
                clr_c[0] = 1'b1;
            end
            else if (s_axi_araddr == A_CNTB)
            begin
                n.rdata = 32'(r.cnt[1]);
                clr_c[1] = 1'b1;
            end
            else if (s_axi_araddr == A_SEL)
            begin
                n.rdata = 32'(r.sel);
            end
            else if (s_axi_araddr == A_DIG && ok)
            begin
                n.rdata = 32'(r.ps2[s]);
                n.mode[s] = M_RDIG;
                n.pull[s] = PULL_DOWN;
                n.pwm_on[s] = 1'b0;
            end
            else if (s_axi_araddr == A_PULL && ok)
            begin
                n.rdata = 32'(r.pull[s]);
            end
            else if (s_axi_araddr == A_MODE && ok)
            begin
                n.rdata = 32'(r.mode[s]);
            end
            else if (s_axi_araddr == A_PWM && ok)
            begin
                n.rdata = 32'(r.duty[s]);
            end
            else if (s_axi_araddr == A_PER_US)
            begin
                n.rdata = 32'(r.per_us);
            end
            else if (s_axi_araddr == A_ANALOG && ok && ANA_MASK[s])
            begin
                n.rdata = 32'(adc_code[ana_ch(s)]);
                n.mode[s] = M_ANALOG;
                n.pull[s] = PULL_NONE;
                n.pwm_on[s] = 1'b0;
            end
            else if (s_axi_araddr == A_TOUCH && ok && TCH_MASK[s])
            begin
                n.rdata = 32'(r.ts2[s[1:0]]);
                n.mode[s] = M_TOUCH;
                n.pull[s] = PULL_UP;
                n.pwm_on[s] = 1'b0;
            end
            else if (s_axi_araddr == A_LEVELS)
            begin
                n.rdata = 32'(r.ps2 & ~GAP_MASK);
            end
            else
            begin
                n.rresp = RESP_ERR;
            end
        end
        n.arready = ~n.rvalid;

        // write channel: address and data taken in either order
        if (r.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (r.awready && s_axi_awvalid)
        begin
            n.aw_have = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (r.wready && s_axi_wvalid)
        begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (r.aw_have && r.w_have && !r.bvalid)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OK;
            if (r.wstrb == 4'h0)
            begin
                n.bresp = RESP_OK;
            end
            else if (r.awaddr == A_SEL)
            begin
                n.sel = wd[4:0];
            end
            else if (r.awaddr == A_DIG && ok)
            begin
                n.dout[s] = wd[0];
                n.mode[s] = M_WDIG;
                n.pwm_on[s] = 1'b0;
            end
            else if (r.awaddr == A_PULL && ok && wd[31:2] == '0 && wd[1:0] != 2'h3)
            begin
                n.pull[s] = wd[1:0];
                n.mode[s] = M_RDIG;
                n.pwm_on[s] = 1'b0;
            end
            else if (r.awaddr == A_PWM && ok && wd <= DUTY_MAX)
            begin
                n.duty[s] = wd[9:0];
                n.pwm_on[s] = 1'b1;
                n.mode[s] = M_ANALOG;
            end
            else if (r.awaddr == A_PER_MS && wd >= MIN_MS && wd <= MAX_MS)
            begin
                n.per_us = ms_us[23:0];
                n.phase = '0;
                n.tick = '0;
            end
            else if (r.awaddr == A_PER_US && wd >= MIN_US && wd <= MAX_US)
            begin
                n.per_us = wd[23:0];
                n.phase = '0;
                n.tick = '0;
            end
            else
            begin
                // short periods, bad pins and read-only words are refused
                n.bresp = RESP_ERR;
            end
        end
        n.awready = ~n.aw_have & ~n.bvalid;
        n.wready = ~n.w_have & ~n.bvalid;

        // a press in the clearing cycle survives the clear
        n.latch = (r.latch & ~clr_l) | press;
        for (int b = 0; b < 2; b++)
        begin
            if (clr_c[b])
            begin
                n.cnt[b] = 16'(press[b]);
            end
            else if (r.cnt[b] != 16'hffff)
            begin
                n.cnt[b] = r.cnt[b] + 16'(press[b]);
            end
        end

        // pin drivers; absent positions never drive or pull
        for (int i = 0; i < NPIN; i++)
        begin
            drv = (n.mode[i] == M_WDIG || n.pwm_on[i]) && !GAP_MASK[i];
            if (n.pwm_on[i])
            begin
                n.pin_o[i] = pwm_lvl(n.duty[i], n.phase, n.per_us);
            end
            else
            begin
                n.pin_o[i] = n.dout[i] & drv;
            end
            n.pin_oe_n[i] = ~drv;
            n.pu_en[i] = !drv && !GAP_MASK[i] && n.pull[i] == PULL_UP;
            n.pd_en[i] = !drv && !GAP_MASK[i] && n.pull[i] == PULL_DOWN;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '0;
            r.per_us <= PER_RST;
            r.pin_oe_n <= '1;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign pin_o = r.pin_o;
    assign pin_oe_n = r.pin_oe_n;
    assign pull_up_en = r.pu_en;
    assign pull_dn_en = r.pd_en;
endmodule

// file: tb/bpp_pins_model.sv
// bpp_pins_model: pin loads and two bouncing buttons
// assumes the pin outputs of bpp_top; an undriven unpulled pin toggles
`timescale 1ns/1ps
module bpp_pins_model (
    input  wire logic        aclk,
    input  wire logic [20:0] pin_o,
    input  wire logic [20:0] pin_oe_n,
    input  wire logic [20:0] pull_up_en,
    input  wire logic [20:0] pull_dn_en,
    input  wire logic [20:0] ext_lvl,
    input  wire logic [20:0] ext_en,
    input  wire logic [1:0]  press,
    output logic [20:0]      pin_i,
    output logic [1:0]       btn_n
);
    logic [20:0]     flt_reg = '0;
    logic [1:0][1:0] bnc_reg = '0;
    // no display scanning here, pins are free for reuse
    always @(posedge aclk)
    begin
        flt_reg <= ~flt_reg;
        for (int b = 0; b < 2; b++)
            bnc_reg[b] <= press[b] ? bnc_reg[b] + 2'(bnc_reg[b] != 2'h3) : 2'h0;
    end
    // contact opens for one cycle after touch-down, debounce must hide it
    always_comb
    begin
        for (int b = 0; b < 2; b++)
            btn_n[b] = !(press[b] && bnc_reg[b] != 2'h1);
        for (int p = 0; p < 21; p++)
            pin_i[p] = !pin_oe_n[p] ? pin_o[p] : ext_en[p] ? ext_lvl[p] : pull_up_en[p] ? 1'h1 :
                       pull_dn_en[p] ? 1'h0 : flt_reg[p];
    end
endmodule

// file: tb/bpp_top_sva.sv
// bpp_top_sva: bus and pin checks on bpp_top ports
// assumes one clock and a sync active-low reset; bound below
`timescale 1ns/1ps
module bpp_top_sva
    import bpp_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic [20:0] pin_oe_n,
    input wire logic [20:0] pull_up_en,
    input wire logic [20:0] pull_dn_en
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb != 4'h0;
    endsequence
    sequence err_late;
        ##2 s_axi_bvalid && s_axi_bresp == RESP_ERR;
    endsequence
    // refused writes still answer, two edges on
    property bad_wr(a, bad);
        (wr_take ##0 (s_axi_awaddr == a && bad)) |-> err_late;
    endproperty
    gap_pins_a:
    assert property (pin_oe_n[18:17] == 2'h3 && (pull_up_en[18:17] | pull_dn_en[18:17]) == 2'h0)
        else $error("absent pin active");
    pull_excl_a:
    assert property ((pull_up_en & pull_dn_en) == 21'h0) else $error("both pulls on");
    drive_nopull_a:
    assert property ((~pin_oe_n & (pull_up_en | pull_dn_en)) == 21'h0) else $error("pull on driven pin");
    levels_gap_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_LEVELS
                     |=> s_axi_rvalid && s_axi_rdata[18:17] == 2'h0) else $error("absent pin level read");
    per_ms_min_a:
    assert property (bad_wr(A_PER_MS, s_axi_wdata < MIN_MS)) else $error("short ms period taken");
    per_us_min_a:
    assert property (bad_wr(A_PER_US, s_axi_wdata < MIN_US)) else $error("short us period taken");
    pull_code_a:
    assert property (bad_wr(A_PULL, s_axi_wdata > 32'h2)) else $error("bad pull code taken");
    wr_lock_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write open during answer");
endmodule
bind bpp_top bpp_top_sva i_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en));

// file: tb/testbench.sv
// testbench: random and corner runs of bpp_top over axi4-lite
// assumes bpp_pins_model on the pins and the bound checker
`timescale 1ns/1ps
module testbench
    import bpp_pkg::*;
;
    logic            aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]      awaddr = '0, araddr = '0;
    logic            awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0]     wdata = '0, rdata, lfsr = 32'h8898895d;
    logic [3:0]      wstrb = 4'hf;
    logic            awready, wready, bvalid, arready, rvalid;
    logic [1:0]      bresp, rresp, btn_n, press = '0;
    logic [20:0]     pin_i, pin_o, oe_n, pu, pd, lvl = '0, ext = '0;
    logic [2:0]      touch = '0;
    logic [5:0][9:0] adc = '0;
    int              errors = 0, samples_checked = 0;

    bpp_top #(.DEB_CYCLES(24'h000004)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .btn_n(btn_n), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(oe_n), .pull_up_en(pu), .pull_dn_en(pd),
        .touch_low(touch), .adc_code(adc));
    bpp_pins_model i_pins (.aclk(aclk), .pin_o(pin_o), .pin_oe_n(oe_n), .pull_up_en(pu),
        .pull_dn_en(pd), .ext_lvl(lvl), .ext_en(ext), .press(press), .pin_i(pin_i), .btn_n(btn_n));

    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // each channel held until its own ready, then the answer compared
    task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic aw, w;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        aw = 1'h0;
        w = 1'h0;
        while (!(aw && w))
        begin
            @(posedge aclk);
            aw |= awready;
            w |= wready;
            if (aw)
                awvalid <= 1'h0;
            if (w)
                wvalid <= 1'h0;
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk(32'(bresp), 32'(e));
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk(32'(rresp), 32'(er));
        if (er == RESP_OK)
            chk(rdata, e);
    endtask
    task automatic test_done;
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
        forever #5 aclk = ~aclk;
    // whole run is near 80k cycles, so 95k cycles means a hang
    initial
    begin
        #950000;
        errors++;
        test_done();
    end

    initial
    begin
        logic [31:0] v;
        int          p, hi, ex, tl;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rc(A_HELD, '0, RESP_OK);
        rc(A_PER_US, 32'h00004e20, RESP_OK);
        rc(A_MODE, 32'(M_UNUSED), RESP_OK);
        rc(8'h3c, '0, RESP_ERR);
        wc(A_HELD, 32'h1, RESP_ERR);
        for (int b = 0; b < 2; b++)
        begin
            press[b] <= 1'h1;
            repeat (12) @(posedge aclk);
            rc(A_HELD, 32'(1 << b), RESP_OK);
            press[b] <= 1'h0;
            repeat (12) @(posedge aclk);
            rc(A_HELD, '0, RESP_OK);
            press[b] <= 1'h1;
            repeat (12) @(posedge aclk);
            press[b] <= 1'h0;
            repeat (12) @(posedge aclk);
            rc(A_LATCH, 32'(1 << b), RESP_OK);
            rc(A_LATCH, '0, RESP_OK);
            rc(A_CNTA + 8'(4 * b), 32'h2, RESP_OK);
            rc(A_CNTA + 8'(4 * b), '0, RESP_OK);
        end
        for (p = 0; p < 21; p++)
        begin
            lfsr = nx(lfsr);
            wc(A_SEL, 32'(p), RESP_OK);
            // absent positions may be selected but refuse every pin access
            if (GAP_MASK[p])
            begin
                rc(A_DIG, '0, RESP_ERR);
                wc(A_DIG, 32'h1, RESP_ERR);
                continue;
            end
            wc(A_DIG, {31'h0, lfsr[0]}, RESP_OK);
            repeat (2) @(posedge aclk);
            chk({30'h0, oe_n[p], pin_o[p]}, {31'h0, lfsr[0]});
            rc(A_MODE, 32'(M_WDIG), RESP_OK);
            wc(A_PULL, 32'h3, RESP_ERR);
            v = 32'(lfsr[2:1] % 2'h3);
            wc(A_PULL, v, RESP_OK);
            rc(A_PULL, v, RESP_OK);
            rc(A_MODE, 32'(M_RDIG), RESP_OK);
            chk({29'h0, oe_n[p], pu[p], pd[p]}, {29'h0, 1'h1, v == PULL_UP, v == PULL_DOWN});
            lvl[p] <= lfsr[3];
            ext[p] <= 1'h1;
            repeat (4) @(posedge aclk);
            rc(A_DIG, {31'h0, lfsr[3]}, RESP_OK);
            rc(A_PULL, 32'(PULL_DOWN), RESP_OK);
        end
        lvl <= lfsr[20:0];
        repeat (4) @(posedge aclk);
        rc(A_LEVELS, 32'(lfsr[20:0] & ~GAP_MASK), RESP_OK);
        for (p = 0; p < 21; p++)
        begin
            if (GAP_MASK[p])
                continue;
            lfsr = nx(lfsr);
            wc(A_SEL, 32'(p), RESP_OK);
            if (ANA_MASK[p])
                adc[p == 10 ? 5 : p] <= lfsr[9:0];
            if (p < 3)
                touch[p] <= lfsr[10];
            repeat (4) @(posedge aclk);
            rc(A_ANALOG, 32'(lfsr[9:0]), ANA_MASK[p] ? RESP_OK : RESP_ERR);
            rc(A_TOUCH, 32'(lfsr[10]), TCH_MASK[p] ? RESP_OK : RESP_ERR);
            v = TCH_MASK[p] ? 32'(PULL_UP) : ANA_MASK[p] ? 32'(PULL_NONE) : 32'(PULL_DOWN);
            rc(A_PULL, v, RESP_OK);
            v = TCH_MASK[p] ? 32'(M_TOUCH) : ANA_MASK[p] ? 32'(M_ANALOG) : 32'(M_RDIG);
            rc(A_MODE, v, RESP_OK);
        end
        wc(A_PER_MS, '0, RESP_ERR);
        wc(A_PER_MS, MIN_MS, RESP_OK);
        rc(A_PER_US, US_PER_MS, RESP_OK);
        wc(A_PER_US, MIN_US - 32'h1, RESP_ERR);
        wc(A_PER_US, MIN_US, RESP_OK);
        rc(A_PER_US, MIN_US, RESP_OK);
        wc(A_SEL, 32'h8, RESP_OK);
        wc(A_PWM, DUTY_MAX + 32'h1, RESP_ERR);
        // one full period counted, so the phase at start does not matter
        tl = int'(MIN_US) * CYC_US;
        for (int k = 0; k < 3; k++)
        begin
            lfsr = nx(lfsr);
            v = k == 0 ? 32'h0 : k == 1 ? DUTY_MAX : 32'(lfsr[9:0]);
            wc(A_PWM, v, RESP_OK);
            rc(A_MODE, 32'(M_ANALOG), RESP_OK);
            repeat (4) @(posedge aclk);
            hi = 0;
            repeat (tl)
            begin
                @(posedge aclk);
                hi += int'(pin_o[8] === 1'h1 && oe_n[8] === 1'h0);
            end
            ex = int'(v) * tl / 1023;
            chk(32'(hi >= ex && hi <= ex + (k == 2 ? CYC_US : 0)), 32'h1);
        end
        test_done();
    end
endmodule
